/* File: common/ood_pkg.sv */
// Purpose: constants and types of the opcode operand field decoder
// Assumes: 16-bit instruction words, APB slave with 32-bit data
// Notes:   register offsets are byte addresses
// Operation
// - general file operand is an 8-bit address, 00h to FFh
// - peripheral operand is a 5-bit address, 00h to 1Fh only
// - pointer control 0 keeps table pointer, 1 increments it after execution
// - byte select 0 targets table latch low byte, 1 the high byte
// - destination bit 0 writes accumulator only, 1 writes file register only
// - alternate destination bit 0 writes file and accumulator, 1 file only
// - don't-care bits are ignored; either value behaves identically
// - bit operand is a 3-bit index into an 8-bit file register
// - global interrupt disable is bit 4 of the cpu status register
// - table pointer is 16 bits wide
// - table latch is 16 bits with separately selectable high and low bytes
// - each instruction is one 16-bit word: opcode then operand fields
// - literal operand is an 8-bit or 13-bit constant per instruction
package ood_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR     = 8'h00;
  localparam logic [7:0] ADDR_FIELDS    = 8'h04;
  localparam logic [7:0] ADDR_LIT       = 8'h08;
  localparam logic [7:0] ADDR_TPTR        = 8'h0C;
  localparam logic [7:0] ADDR_TLATCH      = 8'h10;
  localparam logic [7:0] ADDR_TLATCH_BYTE = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;

  // ----------------------------------------------------------------
  // reset values and bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STATUS = 8'h10;
  localparam logic [15:0] RST_TPTR   = 16'h0000;
  localparam logic [15:0] RST_TLATCH = 16'h0000;
  localparam int          GLINT_BIT  = 4;
  localparam logic [15:0] TPTR_STEP  = 16'h0001;

  // instruction field positions
  localparam int F_MSB    = 7;
  localparam int P_MSB    = 12;
  localparam int P_LSB    = 8;
  localparam int B_MSB    = 10;
  localparam int B_LSB    = 8;
  localparam int K13_MSB  = 12;
  localparam int D_BIT    = 8;
  localparam int TI_BIT   = 8;
  localparam int TT_BIT   = 9;
  localparam int TDIR_BIT = 10;
  localparam int TRW_BIT  = 11;

  // opcode groups
  localparam logic [1:0] GRP_BYTE   = 2'h0;
  localparam logic [1:0] GRP_MOVP   = 2'h1;
  localparam logic [2:0] GRP_BIT    = 3'h4;
  localparam logic [3:0] OPC_TBL    = 4'hA;
  localparam logic [3:0] OPC_LIT8   = 4'hB;
  localparam logic [3:0] OPC_CMPMUL = 4'h3;
  localparam logic [4:0] OPC_STYPE  = 5'h05;
  localparam logic [7:0] OPC_NOPHI  = 8'h00;
  localparam logic [7:0] OPC_MOVWF  = 8'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OOD_FMT_NONE, OOD_FMT_BYTE, OOD_FMT_MOVP, OOD_FMT_BIT,
    OOD_FMT_TBL, OOD_FMT_LIT8, OOD_FMT_LIT13
  } ood_fmt_t;

  typedef struct packed {
    ood_fmt_t    fmt;
    logic [7:0]  file_addr;
    logic [4:0]  periph_addr;
    logic [2:0]  bit_idx;
    logic        tbl_hi;
    logic        tbl_inc;
    logic        tbl_rw;
    logic        dsel_d;
    logic        dsel_s;
    logic        wr_acc;
    logic        wr_file;
    logic [12:0] lit;
    logic        lit13;
    logic        reserved;
  } ood_dec_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ood_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ood_apb_rsp_t;

  typedef struct packed {
    logic [15:0]  ir;
    ood_dec_t     dec;
    logic         done;
    logic [15:0]  tptr;
    logic [15:0]  tlatch;
    logic [7:0]   status;
    ood_apb_rsp_t rsp;
  } ood_state_t;

endpackage

/* File: hdl/ood_field_dec.sv */
// Purpose: pure field extraction from one 16-bit instruction word
// Assumes: word taken live from the write data, before capture; no clock needed
// Notes:   fields come from fixed positions per format class
`timescale 1ns/100ps
module ood_field_dec
  import ood_pkg::*;
(
  // instruction in
  input  wire logic [15:0] instr_word,
  // decoded fields out
  output ood_pkg::ood_dec_t fields
);

  // ----------------------------------------------------------------
  // format class and operand slicing
  // ----------------------------------------------------------------
  // one pass over the opcode bits; no table lookup beyond them
  always_comb
  begin
    fields             = '0;
    fields.file_addr   = instr_word[F_MSB:0];
    if (instr_word[15:14] == GRP_BYTE)
    begin
      fields.fmt = OOD_FMT_BYTE;
      if (instr_word[15:11] == OPC_STYPE)
      begin
        fields.dsel_s  = 1'b1;
        fields.wr_file = 1'b1;
        fields.wr_acc  = ~instr_word[D_BIT];
      end
      else if (instr_word[15:8] == OPC_NOPHI)
      begin
        fields.fmt      = OOD_FMT_NONE;
        fields.reserved = |instr_word[F_MSB:0];
      end
      else if (instr_word[15:8] == OPC_MOVWF)
        fields.wr_file = 1'b1;
      else if (instr_word[15:12] == OPC_CMPMUL)
        fields.reserved = instr_word[B_MSB:B_LSB] == 3'h3 ||
                          instr_word[TRW_BIT] ||
                          (instr_word[B_MSB] && |instr_word[9:8]);
      else
      begin
        fields.dsel_d  = 1'b1;
        fields.wr_file = instr_word[D_BIT];
        fields.wr_acc  = ~instr_word[D_BIT];
      end
    end
    else if (instr_word[15:14] == GRP_MOVP)
    begin
      fields.fmt         = OOD_FMT_MOVP;
      fields.periph_addr = instr_word[P_MSB:P_LSB];
      fields.wr_file     = 1'b1;
    end
    else if (instr_word[15:13] == GRP_BIT)
    begin
      fields.fmt     = OOD_FMT_BIT;
      fields.bit_idx = instr_word[B_MSB:B_LSB];
      fields.wr_file = 1'b1;
    end
    else if (instr_word[15:12] == OPC_TBL)
    begin
      fields.fmt     = OOD_FMT_TBL;
      fields.tbl_rw  = instr_word[TRW_BIT];
      fields.tbl_hi  = instr_word[TT_BIT];
      // latch-only forms carry a don't-care here, so it never counts
      fields.tbl_inc = instr_word[TRW_BIT] & instr_word[TI_BIT];
      fields.wr_file = ~instr_word[TDIR_BIT];
    end
    else if (instr_word[15:12] == OPC_LIT8)
    begin
      fields.fmt = OOD_FMT_LIT8;
      fields.lit = {5'h00, instr_word[F_MSB:0]};
    end
    else
    begin
      fields.fmt   = OOD_FMT_LIT13;
      fields.lit   = instr_word[K13_MSB:0];
      fields.lit13 = 1'b1;
    end
  end

endmodule

/* File: hdl/ood_core.sv */
// Purpose: APB-visible operand decoder with table pointer, table latch
//          and cpu status register
// Assumes: one clock, pclk at 25 MHz; presetn asynchronous, active low
// Notes:   one wait state on every APB access; writes land at the
//          edge where pready is sampled high
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module ood_core
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire ood_pkg::ood_apb_req_t apb_req,
  output ood_pkg::ood_apb_rsp_t      apb_rsp,
  // decode results
  output ood_pkg::ood_dec_t          fields,
  output logic [15:0]                instr_word,
  output logic                       dec_valid,
  // table and status state
  output logic [15:0]                table_pointer,
  output logic [15:0]                table_latch,
  output logic                       global_irq_disable
);
  import ood_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ood_state_t  st_reg;
  ood_state_t  st_next;
  ood_dec_t    wr_dec;
  logic        acc_start;
  logic        commit;
  logic        wr_commit;
  logic        rd_err;
  logic [31:0] rd_word;
  logic        do_inc;

  // ----------------------------------------------------------------
  // decoder on the write data path
  // ----------------------------------------------------------------
  // decoding pwdata directly lets the fields land with the word itself
  ood_field_dec u_dec
  (
    .instr_word (apb_req.pwdata[15:0]),
    .fields     (wr_dec)
  );

  // ----------------------------------------------------------------
  // bus phase decode
  // ----------------------------------------------------------------
  // first access cycle raises pready, the next one completes
  assign acc_start = apb_req.psel & apb_req.penable & ~st_reg.rsp.pready;
  assign commit    = apb_req.psel & apb_req.penable & st_reg.rsp.pready;
  assign wr_commit = commit & apb_req.pwrite & ~st_reg.rsp.pslverr;

  // pointer step is due one cycle after a table instruction lands
  assign do_inc = st_reg.done & (st_reg.dec.fmt == OOD_FMT_TBL) &
                  st_reg.dec.tbl_inc;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped offsets answer zero with an error flag
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (apb_req.paddr)
      ADDR_INSTR:
        rd_word = {16'h0000, st_reg.ir};
      ADDR_FIELDS:
      begin
        rd_word[7:0]   = st_reg.dec.file_addr;
        rd_word[12:8]  = st_reg.dec.periph_addr;
        rd_word[15:13] = st_reg.dec.bit_idx;
        rd_word[16]    = st_reg.dec.tbl_hi;
        rd_word[17]    = st_reg.dec.tbl_inc;
        rd_word[18]    = st_reg.dec.wr_acc;
        rd_word[19]    = st_reg.dec.wr_file;
        rd_word[20]    = st_reg.dec.reserved;
        rd_word[23:21] = st_reg.dec.fmt;
        rd_word[24]    = st_reg.dec.tbl_rw;
        rd_word[25]    = st_reg.dec.dsel_d;
        rd_word[26]    = st_reg.dec.dsel_s;
      end
      ADDR_LIT:
      begin
        rd_word[12:0] = st_reg.dec.lit;
        rd_word[16]   = st_reg.dec.lit13;
      end
      ADDR_TPTR:
        rd_word = {16'h0000, st_reg.tptr};
      ADDR_TLATCH:
        rd_word = {16'h0000, st_reg.tlatch};
      ADDR_TLATCH_BYTE:
        rd_word = {24'h00_0000, st_reg.dec.tbl_hi ?
                   st_reg.tlatch[15:8] : st_reg.tlatch[7:0]};
      ADDR_STATUS:
        rd_word = {24'h00_0000, st_reg.status};
      default:
        rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;

    // response: held stable from the access start to completion
    st_next.rsp.pready = acc_start;
    if (acc_start)
    begin
      st_next.rsp.pslverr = rd_err;
      st_next.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end
    else if (commit)
    begin
      st_next.rsp.pslverr = 1'b0;
      st_next.rsp.prdata  = 32'h0000_0000;
    end

    // register writes
    if (wr_commit)
    begin
      unique case (apb_req.paddr)
        ADDR_INSTR:
        begin
          st_next.ir   = apb_req.pwdata[15:0];
          st_next.dec  = wr_dec;
          st_next.done = 1'b1;
        end
        ADDR_TPTR:
          st_next.tptr = apb_req.pwdata[15:0];
        ADDR_TLATCH:
          st_next.tlatch = apb_req.pwdata[15:0];
        ADDR_TLATCH_BYTE:
        begin
          if (st_reg.dec.tbl_hi)
            st_next.tlatch[15:8] = apb_req.pwdata[7:0];
          else
            st_next.tlatch[7:0] = apb_req.pwdata[7:0];
        end
        ADDR_STATUS:
          st_next.status = apb_req.pwdata[7:0];
        default:
          st_next.done = 1'b0;
      endcase
    end

    // the execution-side step outranks a same-cycle software write
    if (do_inc)
      st_next.tptr = st_reg.tptr + TPTR_STEP;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg        <= '0;
      st_reg.tptr   <= RST_TPTR;
      st_reg.tlatch <= RST_TLATCH;
      st_reg.status <= RST_STATUS;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign apb_rsp            = st_reg.rsp;
  assign fields             = st_reg.dec;
  assign instr_word         = st_reg.ir;
  assign dec_valid          = st_reg.done;
  assign table_pointer      = st_reg.tptr;
  assign table_latch        = st_reg.tlatch;
  assign global_irq_disable = st_reg.status[GLINT_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence instr_write_s;
    wr_commit && apb_req.paddr == ADDR_INSTR;
  endsequence

  sequence tbl_inc_s;
    st_reg.dec.fmt == OOD_FMT_TBL && st_reg.dec.tbl_inc;
  endsequence

  sequence tbl_hold_s;
    st_reg.dec.fmt == OOD_FMT_TBL && !st_reg.dec.tbl_inc &&
    !(wr_commit && apb_req.paddr == ADDR_TPTR);
  endsequence

  property file_addr_p;
    instr_write_s |=> fields.file_addr == instr_word[F_MSB:0] && dec_valid;
  endproperty

  property tbl_inc_p;
    instr_write_s ##1 tbl_inc_s |=>
      table_pointer == $past(table_pointer) + TPTR_STEP;
  endproperty

  property tbl_hold_p;
    instr_write_s ##1 tbl_hold_s |=> $stable(table_pointer);
  endproperty

  file_addr_a: assert property (file_addr_p)
    else $error("file address does not follow the instruction word");

  periph_addr_a: assert property (
    fields.fmt == OOD_FMT_MOVP |->
      fields.periph_addr == instr_word[P_MSB:P_LSB] &&
      fields.file_addr == instr_word[F_MSB:0])
    else $error("peripheral address not taken from its field");

  tbl_inc_a: assert property (tbl_inc_p)
    else $error("table pointer did not step after execution");

  tbl_hold_a: assert property (tbl_hold_p)
    else $error("table pointer moved without increment control");

  latch_byte_a: assert property (
    wr_commit && apb_req.paddr == ADDR_TLATCH_BYTE && !fields.tbl_hi |=>
      table_latch[15:8] == $past(table_latch[15:8]) &&
      table_latch[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("low byte select disturbed the high byte");

  dest_d_a: assert property (
    dec_valid && fields.dsel_d |->
      fields.wr_file == instr_word[D_BIT] &&
      fields.wr_acc == !instr_word[D_BIT])
    else $error("destination bit steers the wrong target");

  dest_s_a: assert property (
    dec_valid && fields.dsel_s |->
      fields.wr_file && fields.wr_acc == !instr_word[D_BIT])
    else $error("alternate destination bit steers the wrong target");

  dont_care_a: assert property (
    fields.fmt == OOD_FMT_TBL && !fields.tbl_rw |-> !fields.tbl_inc)
    else $error("don't-care bit changed behaviour");

  bit_idx_a: assert property (
    fields.fmt == OOD_FMT_BIT |->
      fields.bit_idx == instr_word[B_MSB:B_LSB])
    else $error("bit index not taken from its field");

  glint_a: assert property (
    wr_commit && apb_req.paddr == ADDR_STATUS |=>
      global_irq_disable == $past(apb_req.pwdata[GLINT_BIT]))
    else $error("interrupt disable does not track status bit four");

  lit13_a: assert property (
    fields.fmt == OOD_FMT_LIT13 |->
      fields.lit13 && fields.lit == instr_word[K13_MSB:0])
    else $error("long literal not taken from its field");

  apb_wait_a: assert property (
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("access phase not answered after one wait state");

endmodule

/* File: dv/ood_prog_mem.sv */
// Purpose: program memory model handing 16-bit instruction words to the bench
// Assumes: combinational fetch on a 4-bit word index
// Notes:   image holds only assigned opcodes with unused bits zero
`timescale 1ns/100ps
module ood_prog_mem
(
  // fetch port
  input  wire logic [3:0]  addr,
  output logic      [15:0] word
);
  // ----------------------------------------------------------------
  // program image
  // ----------------------------------------------------------------
  // whole words only, unused bits zero, no reserved opcode: a real
  // image from a code generator must keep to the same discipline
  always_comb
  begin
    case (addr)
      4'h0:    word = 16'h0FFF;
      4'h1:    word = 16'h0E00; // add, d clear, file 00h
      4'h2:    word = 16'h28AB; // clear, s clear
      4'h3:    word = 16'h29AB; // clear, s set
      4'h4:    word = 16'h7F12; // move file to peripheral 1Fh
      4'h5:    word = 16'h8F34; // bit class, bit 7
      4'h6:    word = 16'hAB05; // table read, high byte, increment
      4'h7:    word = 16'hAA05; // table read, high byte, keep
      4'h8:    word = 16'hA200; // latch read, don't-care bit clear
      4'h9:    word = 16'hA300; // latch read, don't-care bit set
      4'hA:    word = 16'hA000; // latch read, low byte
      4'hB:    word = 16'hB0A5; // 8-bit literal
      4'hC:    word = 16'hDFFF; // 13-bit literal
      default: word = 16'h0000; // no operation
    endcase
  end
endmodule

/* File: dv/test_opcode_operand_field_decoder.sv */
// Purpose: self-checking bench for the operand field decoder
// Assumes: apb with one wait state, words fetched from the memory model
// Notes:   expectations come from the field rules, not the design
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module test_opcode_operand_field_decoder;
  import ood_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         pclk;
  logic         presetn;
  ood_apb_req_t req;
  ood_apb_rsp_t rsp;
  ood_dec_t     fields;
  ood_dec_t     f_save;
  logic [15:0]  instr_word;
  logic [15:0]  table_pointer;
  logic [15:0]  table_latch;
  logic         dec_valid;
  logic         gid;
  logic [3:0]   pm_addr;
  logic [15:0]  pm_word;
  logic [31:0]  rd;
  logic         er;
  int           n_fail;
  int           checked;
  int           cycles;
  int           dv_cnt;
  int           n_dec;

  ood_core u_ood_core (
    .pclk               (pclk),
    .presetn            (presetn),
    .apb_req            (req),
    .apb_rsp            (rsp),
    .fields             (fields),
    .instr_word         (instr_word),
    .dec_valid          (dec_valid),
    .table_pointer      (table_pointer),
    .table_latch        (table_latch),
    .global_irq_disable (gid)
  );

  ood_prog_mem u_ood_prog_mem (
    .addr (pm_addr),
    .word (pm_word)
  );

  // ----------------------------------------------------------------
  // clock, watchdog, pulse monitor
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // a hang anywhere ends the run as a failure
  always @(posedge pclk)
  begin
    cycles++;
    if (dec_valid === 1'b1)
      dv_cnt++;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    begin
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // request stands until pready is seen high at a rising edge; data taken there
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    begin
      n = 0;
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= wd;
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1 && n < 32)
      begin
        @(posedge pclk);
        n++;
      end
      if (n == 32)
        n_fail++;
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // fetch one word from the model and hand it to the decoder
  task automatic dec(input logic [3:0] idx);
    begin
      pm_addr = idx;
      @(posedge pclk);
      xfer(1'h1, ADDR_INSTR, {16'h0000, pm_word});
      repeat (2) @(posedge pclk);
      n_dec++;
      `CHK(instr_word, pm_word);
      `CHK(dv_cnt, n_dec);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    req     = '0;
    pm_addr = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(table_pointer, 16'h0000);
    `CHK(table_latch, 16'h0000);
    `CHK(gid, 1'h1);
    xfer(1'h0, ADDR_STATUS, 32'h00000000);
    `CHK(rd, 32'h00000010);
    // byte class, both ends of the file range and both destinations
    dec(4'h0);
    `CHK(fields.fmt, OOD_FMT_BYTE);
    `CHK(fields.file_addr, 8'hFF);
    `CHK({fields.wr_acc, fields.wr_file}, 2'h1);
    xfer(1'h0, ADDR_FIELDS, 32'h00000000);
    `CHK({rd[19:18], rd[7:0]}, 10'h2FF);
    dec(4'h1);
    `CHK(fields.file_addr, 8'h00);
    `CHK({fields.wr_acc, fields.wr_file}, 2'h2);
    dec(4'h2);
    `CHK({fields.wr_acc, fields.wr_file}, 2'h3);
    dec(4'h3);
    `CHK({fields.wr_acc, fields.wr_file}, 2'h1);
    dec(4'h4);
    `CHK(fields.fmt, OOD_FMT_MOVP);
    `CHK({fields.periph_addr, fields.file_addr}, 13'h1F12);
    dec(4'h5);
    `CHK(fields.fmt, OOD_FMT_BIT);
    `CHK({fields.bit_idx, fields.file_addr}, 11'h734);
    // pointer wraps at the top of its 16-bit range
    xfer(1'h1, ADDR_TPTR, 32'h0000FFFF);
    dec(4'h6);
    `CHK({fields.tbl_hi, fields.tbl_inc}, 2'h3);
    `CHK(table_pointer, 16'h0000);
    dec(4'h7);
    `CHK(fields.tbl_inc, 1'h0);
    `CHK(table_pointer, 16'h0000);
    // don't-care bit must not change anything
    dec(4'h8);
    f_save = fields;
    dec(4'h9);
    `CHK(fields, f_save);
    `CHK(table_pointer, 16'h0000);
    // byte selects into the latch
    xfer(1'h1, ADDR_TLATCH, 32'h00001234);
    `CHK(table_latch, 16'h1234);
    xfer(1'h0, ADDR_TLATCH_BYTE, 32'h00000000);
    `CHK(rd, 32'h00000012);
    dec(4'hA);
    xfer(1'h0, ADDR_TLATCH_BYTE, 32'h00000000);
    `CHK(rd, 32'h00000034);
    xfer(1'h1, ADDR_TLATCH_BYTE, 32'h000000AB);
    `CHK(table_latch, 16'h12AB);
    // literals of both widths
    dec(4'hB);
    `CHK({fields.lit13, fields.lit}, 14'h00A5);
    xfer(1'h0, ADDR_LIT, 32'h00000000);
    `CHK(rd, 32'h000000A5);
    dec(4'hC);
    `CHK({fields.lit13, fields.lit}, 14'h3FFF);
    xfer(1'h0, ADDR_INSTR, 32'h00000000);
    `CHK(rd, 32'h0000DFFF);
    dec(4'hD);
    `CHK(fields.reserved, 1'h0);
    // words written straight over the bus reach forms the image avoids
    xfer(1'h1, ADDR_INSTR, 32'h00000001);
    `CHK({fields.fmt, fields.reserved}, 4'h1);
    xfer(1'h1, ADDR_INSTR, 32'h00003301);
    `CHK(fields.reserved, 1'h1);
    xfer(1'h0, ADDR_FIELDS, 32'h00000000);
    `CHK(rd[23:20], 4'h3);
    xfer(1'h1, ADDR_INSTR, 32'h00000155);
    `CHK({fields.wr_acc, fields.wr_file, fields.file_addr}, 10'h155);
    xfer(1'h1, ADDR_INSTR, 32'h0000AC00);
    `CHK({fields.fmt, fields.tbl_rw, fields.wr_file}, 5'h12);
    // unmapped offset is refused
    xfer(1'h0, 8'h1C, 32'h00000000);
    `CHK({er, rd}, 33'h100000000);
    // status bit 4 is an ordinary register bit
    xfer(1'h1, ADDR_STATUS, 32'h00000000);
    `CHK(gid, 1'h0);
    xfer(1'h1, ADDR_STATUS, 32'h00000010);
    `CHK(gid, 1'h1);
    final_report();
  end
endmodule
